// ===== hw/nbc_map.svh
// nv_brownout_control constants: bit positions, reset values, timing counts
// assumes inclusion from design files only
`ifndef NBC_MAP_SVH
`define NBC_MAP_SVH
`define NBC_BIT_BOD_EN      0
`define NBC_BIT_BOD_RST_EN  1
`define NBC_NUM_BITS        2
`define NBC_RESET_VALUE     2'h0
`define NBC_CLK_PERIOD_NS   25
`define NBC_PROG_TIME_NS    100
`define NBC_PROG_CYCLES     ((`NBC_PROG_TIME_NS + `NBC_CLK_PERIOD_NS - 1) / `NBC_CLK_PERIOD_NS)
`endif

// ===== hw/nbc_pkg.sv
// nv_brownout_control types
// assumes nothing of its surroundings
`default_nettype none
package nbc_pkg;
    typedef enum logic [1:0] {
        NBC_CMD_NONE  = 2'h0,
        NBC_CMD_SET   = 2'h1,
        NBC_CMD_CLEAR = 2'h2
    } nbc_cmd_t;
    typedef enum logic [1:0] {
        NBC_ST_IDLE  = 2'h0,
        NBC_ST_PROG  = 2'h1,
        NBC_ST_ERASE = 2'h2
    } nbc_state_t;
endpackage : nbc_pkg
`default_nettype wire

// ===== hw/nbc_cell.sv
// nv_brownout_control: one non-volatile bit cell model with program delay
// assumes a single clock; the cell content ignores rst_n (retained storage)
`timescale 1ns/1ps
`default_nettype none
`include "nbc_map.svh"
module nbc_cell #(
    parameter int PROG_CYCLES = `NBC_PROG_CYCLES
) (
    input  wire logic mclk,
    input  wire logic wr,
    input  wire logic wdata,
    output logic      bit_q,
    output logic      busy
);
    typedef struct packed {
        logic       val;
        logic       pend;
        logic       pval;
        logic [7:0] cnt;
    } nbc_cell_st_t;
    // blank cell powers up cleared; an unknown start would never erase
    nbc_cell_st_t st = '0;
    nbc_cell_st_t next_st;
    // =========================================
    // program sequencing
    always_comb begin
        next_st = st;
        if (wr) begin
            next_st.pend = 1'b1;
            next_st.pval = wdata;
            next_st.cnt  = 8'(PROG_CYCLES);
        end else if (st.pend) begin
            if (st.cnt <= 8'h01) begin
                next_st.pend = 1'b0;
                next_st.val  = st.pval;
            end else begin
                next_st.cnt = st.cnt - 8'h01;
            end
        end
    end
    // no reset: retained across every reset, like the flash cell
    always_ff @(posedge mclk) begin
        st <= next_st;
    end
    assign bit_q = st.val;
    assign busy  = st.pend;
endmodule : nbc_cell
`default_nettype wire

// ===== hw/nbc_top.sv
// nv_brownout_control top: two retained config bits driving detector enable and brownout reset enable
// assumes one-cycle command pulses from the flash command controller, erase
// level synchronous to mclk
//
// Overview of operation
// - two retained bits hold brownout configuration
// - set or clear command updates addressed bit
// - bit zero drives detector enable
// - erase clears bit zero
// - bit one drives brownout reset enable
// - erase clears bit one
`timescale 1ns/1ps
`default_nettype none
`include "nbc_map.svh"
module nbc_top #(
    parameter int PROG_CYCLES = `NBC_PROG_CYCLES
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire nbc_pkg::nbc_cmd_t cmd,
    input  wire logic             cmd_bit,
    input  wire logic             erase,
    output logic                  bod_en,
    output logic                  bod_rst_en,
    output logic                  cmd_busy
);
    typedef struct packed {
        logic bod_en;
        logic bod_rst_en;
        logic busy;
    } nbc_top_st_t;
    nbc_top_st_t st = '0;
    nbc_top_st_t next_st;
    logic [`NBC_NUM_BITS-1:0] cell_q;
    logic [`NBC_NUM_BITS-1:0] cell_busy;
    logic [`NBC_NUM_BITS-1:0] cell_wr;
    logic [`NBC_NUM_BITS-1:0] cell_wd;
    logic                     cmd_ok;
    // worst case: a program taken just before erase rises, then the clear runs
    localparam int ERASE_SPAN = 2 * PROG_CYCLES + 2;
    // =========================================
    // command decode
    // commands while busy are dropped; erase overrides any command
    assign cmd_ok = (cmd != nbc_pkg::NBC_CMD_NONE) && (cell_busy == 2'h0) && !erase;
    genvar gi;
    generate
        for (gi = 0; gi < `NBC_NUM_BITS; gi++) begin : g_cell
            assign cell_wr[gi] = erase ? !cell_busy[gi] && cell_q[gi]
                                       : cmd_ok && (cmd_bit == 1'(gi));
            assign cell_wd[gi] = !erase && (cmd == nbc_pkg::NBC_CMD_SET);
            nbc_cell #(.PROG_CYCLES(PROG_CYCLES)) u_cell (
                .mclk  (mclk),
                .wr    (cell_wr[gi]),
                .wdata (cell_wd[gi]),
                .bit_q (cell_q[gi]),
                .busy  (cell_busy[gi])
            );
        end
    endgenerate
    // =========================================
    // output staging
    always_comb begin
        next_st            = st;
        next_st.bod_en     = cell_q[`NBC_BIT_BOD_EN];
        next_st.bod_rst_en = cell_q[`NBC_BIT_BOD_RST_EN];
        next_st.busy       = (cell_busy != 2'h0) || (cell_wr != 2'h0);
        // outputs follow retained cells, not reset: reset only clears busy
        if (!rst_n) begin
            next_st.busy = 1'b0;
        end
    end
    always_ff @(posedge mclk) begin
        st <= next_st;
    end
    assign bod_en     = st.bod_en;
    assign bod_rst_en = st.bod_rst_en;
    assign cmd_busy   = st.busy;
    // =========================================
    // checks
    bod_follow_a: assert property (@(posedge mclk) ##1 bod_en == $past(cell_q[0]))
        else $error("detector enable does not follow bit zero");
    rst_follow_a: assert property (@(posedge mclk) ##1 bod_rst_en == $past(cell_q[1]))
        else $error("reset enable does not follow bit one");
    // short erase pulses break the hold rule, so only a held erase is judged
    erase_clr_a: assert property (@(posedge mclk) disable iff (!erase)
        $rose(erase) |-> ##(ERASE_SPAN) !bod_en && !bod_rst_en)
        else $error("erase did not clear bits");
    set_bit0_a: assert property (@(posedge mclk) disable iff (erase)
        (cmd_ok && cmd == nbc_pkg::NBC_CMD_SET && !cmd_bit) |-> ##(PROG_CYCLES+2) bod_en)
        else $error("set command not applied");
    clr_bit0_a: assert property (@(posedge mclk) disable iff (erase)
        (cmd_ok && cmd == nbc_pkg::NBC_CMD_CLEAR && !cmd_bit) |-> ##(PROG_CYCLES+2) !bod_en)
        else $error("clear command not applied to bit zero");
    set_bit1_a: assert property (@(posedge mclk) disable iff (erase)
        (cmd_ok && cmd == nbc_pkg::NBC_CMD_SET && cmd_bit) |-> ##(PROG_CYCLES+2) bod_rst_en)
        else $error("set command not applied to bit one");
    clr_bit1_a: assert property (@(posedge mclk) disable iff (erase)
        (cmd_ok && cmd == nbc_pkg::NBC_CMD_CLEAR && cmd_bit) |-> ##(PROG_CYCLES+2) !bod_rst_en)
        else $error("clear command not applied to bit one");
    busy_rise_a: assert property (@(posedge mclk)
        (rst_n && cmd_ok) |=> cmd_busy)
        else $error("busy not raised for an accepted command");
    late_change_a: assert property (@(posedge mclk) disable iff (erase)
        cmd_ok |-> ##(PROG_CYCLES+1) $stable(bod_en) && $stable(bod_rst_en))
        else $error("enables moved before the program finished");
    stable_rst_a: assert property (@(posedge mclk)
        (!rst_n && !(|cell_busy) && !(|$past(cell_busy)))
        |=> $stable(bod_en) && $stable(bod_rst_en))
        else $error("enables moved under reset");
endmodule : nbc_top
`default_nettype wire

// ===== verification/nbc_partner.sv
// nbc far side: brownout detector and reset controller model
// assumes enables from nbc_top; brownout level driven by bench
`timescale 1ns/1ps
`default_nettype none
module nbc_partner (
    input  wire logic bod_en,
    input  wire logic bod_rst_en,
    input  wire logic brownout,
    output logic      det_hit,
    output logic      sys_rst
);
    // ==========
    // detector and reset request
    assign det_hit = brownout & bod_en;
    assign sys_rst = det_hit & bod_rst_en;
endmodule : nbc_partner
`default_nettype wire

// ===== verification/testbench.sv
// nbc bench: erase, set, clear, reset retention, refused command
// assumes nbc_top with shortened program time
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic mclk = 0, rst_n = 0, cmd_bit = 0, erase = 0, brownout = 1;
    nbc_pkg::nbc_cmd_t cmd = nbc_pkg::NBC_CMD_NONE;
    logic bod_en, bod_rst_en, cmd_busy, det_hit, sys_rst;
    int bad_count = 0, checks_done = 0, cyc = 0;
    always #12.5 mclk = ~mclk;
    nbc_top #(.PROG_CYCLES(2)) u_dut (.mclk(mclk), .rst_n(rst_n), .cmd(cmd),
        .cmd_bit(cmd_bit), .erase(erase), .bod_en(bod_en),
        .bod_rst_en(bod_rst_en), .cmd_busy(cmd_busy));
    nbc_partner u_far (.bod_en(bod_en), .bod_rst_en(bod_rst_en),
        .brownout(brownout), .det_hit(det_hit), .sys_rst(sys_rst));
    // ==========
    // shared tasks
    task automatic chk(string n, logic [1:0] s, logic [1:0] e);
        checks_done++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %b seen %b", n, e, s);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_of_test
    task automatic t_erase();
        erase = 1;
        repeat (8) @(negedge mclk);
        erase = 0;
        @(negedge mclk);
        chk("erased", {bod_rst_en, bod_en}, 2'h0);
        $display("erase done");
    endtask : t_erase
    // old value must stand until the program finishes
    task automatic t_cmd(nbc_pkg::nbc_cmd_t c, logic b, logic [1:0] o, logic [1:0] e);
        int n;
        n = 0;
        cmd = c;
        cmd_bit = b;
        @(negedge mclk);
        cmd = nbc_pkg::NBC_CMD_NONE;
        chk("early", {bod_rst_en, bod_en}, o);
        chk("busy", {1'b0, cmd_busy}, 2'h1);
        while (cmd_busy === 1'b1 && n < 50) begin
            @(negedge mclk);
            n++;
        end
        chk("done", {1'b0, cmd_busy}, 2'h0);
        repeat (2) @(negedge mclk);
        chk("bits", {bod_rst_en, bod_en}, e);
        chk("far", {sys_rst, det_hit}, {e[1] & e[0], e[0]});
        $display("command done");
    endtask : t_cmd
    task automatic t_reset();
        rst_n = 0;
        repeat (3) @(negedge mclk);
        rst_n = 1;
        @(negedge mclk);
        chk("retained", {bod_rst_en, bod_en}, 2'h3);
        brownout = 0;
        @(negedge mclk);
        chk("quiet", {sys_rst, det_hit}, 2'h0);
        brownout = 1;
        $display("reset done");
    endtask : t_reset
    // second request lands while the first programs, so it must be dropped
    task automatic t_refused();
        cmd = nbc_pkg::NBC_CMD_SET;
        cmd_bit = 1;
        @(negedge mclk);
        cmd_bit = 0;
        @(negedge mclk);
        cmd = nbc_pkg::NBC_CMD_NONE;
        repeat (8) @(negedge mclk);
        chk("refused", {bod_rst_en, bod_en}, 2'h2);
        $display("refused done");
    endtask : t_refused
    // ==========
    // sequence and timeout
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            bad_count++;
            end_of_test();
        end
    end
    initial begin
        repeat (3) @(negedge mclk);
        rst_n = 1;
        @(negedge mclk);
        t_erase();
        t_cmd(nbc_pkg::NBC_CMD_SET, 0, 2'h0, 2'h1);
        t_cmd(nbc_pkg::NBC_CMD_SET, 1, 2'h1, 2'h3);
        t_reset();
        t_cmd(nbc_pkg::NBC_CMD_CLEAR, 0, 2'h3, 2'h2);
        t_cmd(nbc_pkg::NBC_CMD_SET, 0, 2'h2, 2'h3);
        t_cmd(nbc_pkg::NBC_CMD_CLEAR, 1, 2'h3, 2'h1);
        t_erase();
        t_refused();
        t_erase();
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
